// [crcw_pkg.sv]
/*
  Constants and carrier types of the programmable CRC block.
  Assumes one clock (hclk, 40 MHz) and an active-low asynchronous reset.
*/
package crcw_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // Control and FIFO state
  localparam logic [7:0] OFS_CFG    = 8'h04; // Width and length
  localparam logic [7:0] OFS_POLY_L = 8'h08; // Terms x^15..x^1
  localparam logic [7:0] OFS_POLY_H = 8'h0c; // Terms x^31..x^16
  localparam logic [7:0] OFS_DATA   = 8'h10; // FIFO push
  localparam logic [7:0] OFS_RESULT = 8'h14; // Result, write seeds
  localparam logic [7:0] OFS_STAT   = 8'h18; // Sticky events
  localparam logic [7:0] OFS_MASK   = 8'h1c; // Interrupt mask

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WIDTH_LSB = 8;  // Data width field low bit
  localparam int LEN_LSB   = 0;  // Length field low bit
  localparam int VWC_LSB   = 8;  // Word count low bit
  localparam int FULL_BIT  = 7;  // FIFO full flag
  localparam int EMPTY_BIT = 6;  // FIFO empty flag
  localparam int ISEL_BIT  = 5;  // Interrupt select
  localparam int GO_BIT    = 4;  // Start shifter
  localparam int LSBF_BIT  = 3;  // Shift order
  localparam int EV_CRC    = 0;  // Status: selected CRC event
  localparam int EV_OVF    = 1;  // Status: push to full FIFO

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int         FIFO_DEPTH = 16;       // Storage words
  localparam logic [4:0] DEPTH_LONG = 5'h08;    // Limit, long poly
  localparam logic [4:0] DEPTH_SHRT = 5'h10;    // Limit, short poly
  localparam logic [4:0] LEN_SPLIT  = 5'h07;    // Length boundary
  localparam logic [1:0] STAT_RESET = 2'h0;     // Status at reset

  // Configuration handed to the shift engine
  typedef struct packed {
    logic [4:0]  data_word_width_minus_one; // Word width - 1
    logic [4:0]  poly_length_minus_one;     // Poly length - 1
    logic [31:0] poly;                      // Term enables
    logic        lsb_first_select;          // Shift order
  } crcw_cfg_type;

  // Shift engine state
  typedef struct packed {
    logic        busy;  // Word in flight
    logic        done;  // Last bit shifted
    logic [4:0]  cnt;   // Bit index
    logic [31:0] word;  // Word being shifted
    logic [31:0] crc;   // Running remainder
  } crcw_eng_type;

  // Top-level state
  typedef struct packed {
    logic [4:0]  data_word_width_minus_one; // Config field
    logic [4:0]  poly_length_minus_one;     // Config field
    logic [15:1] poly_lo;                   // Low terms
    logic [15:0] poly_hi;                   // High terms
    logic        shifter_go;                // Start bit
    logic        lsb_first_select;          // Shift order
    logic        irq_event_select;          // Event choice
    logic [1:0]  status;                    // Sticky events
    logic [1:0]  mask;                      // Interrupt mask
    logic [FIFO_DEPTH-1:0][31:0] fifo;      // Word storage
    logic [3:0]  wr_ptr;                    // Push index
    logic [3:0]  rd_ptr;                    // Pop index
    logic [4:0]  valid_word_count;          // Occupancy
    logic        wr_pend;                   // Write data phase
    logic        rd_wait;                   // Read wait state
    logic [7:0]  addr;                      // Latched address
    logic [31:0] hrdata;                    // Read data
  } crcw_top_type;

endpackage

// [crcw_shift_engine.sv]
/*
  Serial CRC shift engine, one data bit per clock.
  Assumes configuration is held stable while a word shifts.
*/
module crcw_shift_engine
  import crcw_pkg::*;
(
  input  wire logic         hclk,       // Clock
  input  wire logic         hresetn,    // Async reset, low
  input  wire crcw_cfg_type cfg,        // Width, length, terms
  input  wire logic         word_valid, // Take a new word
  input  wire logic [31:0]  word,       // Word to shift
  input  wire logic         seed_load,  // Preload remainder
  input  wire logic [31:0]  seed,       // Preload value
  output logic              busy,       // Word in flight
  output logic              done,       // One-cycle finish pulse
  output logic [31:0]       crc         // Remainder
);

  crcw_eng_type st;       // Registered state
  crcw_eng_type next_st;  // Next state
  logic [4:0]   bit_idx;  // Bit taken this cycle
  logic         fb;       // Feedback bit
  logic [31:0]  step;     // Remainder after one bit

  // --------------------------------------------------------------
  // Bit selection and feedback
  // --------------------------------------------------------------
  // Pick bit by shift order
  assign bit_idx = cfg.lsb_first_select ? st.cnt
                 : 5'(cfg.data_word_width_minus_one - st.cnt);
  // Top stage set by length field
  assign fb = st.word[bit_idx] ^ st.crc[cfg.poly_length_minus_one];

  // One stage per remainder bit
  for (genvar i = 0; i < 32; i++) begin : g_stage
    localparam logic [4:0] IDX = 5'(i); // Stage number
    if (i == 0) begin : g_x0
      assign step[i] = fb;
    end else begin : g_xn
      // Stage beyond length stays clear
      assign step[i] = (IDX > cfg.poly_length_minus_one) ? 1'b0
                     : st.crc[i-1] ^ (fb & cfg.poly[i]);
    end
  end

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (st.busy) begin
      next_st.crc = step;
      // Word ends after width bits
      if (st.cnt == cfg.data_word_width_minus_one) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = 5'(st.cnt + 5'h01);
      end
    end else if (word_valid) begin
      next_st.busy = 1'b1;
      next_st.cnt  = 5'h00;
      next_st.word = word;
    end else if (seed_load) begin
      next_st.crc = seed;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.done;
  assign crc  = st.crc;

endmodule

// [crcw_top.sv]
/*
  Programmable CRC block: AHB-Lite registers, word FIFO, interrupt.
  Assumes a single AHB-Lite master; hreadyout is the bus hready.
*/
module crcw_top
  import crcw_pkg::*;
(
  input  wire logic        hclk,      // Clock, 40 MHz
  input  wire logic        hresetn,   // Async reset, low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [2:0]  hsize,     // Transfer size
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Slave ready
  output logic             hresp,     // Always OKAY
  output logic [31:0]      hrdata,    // Read data
  output logic             irq        // Level interrupt
);

  crcw_top_type st;       // Registered state
  crcw_top_type next_st;  // Next state
  crcw_cfg_type cfg;      // Engine configuration
  logic         take;     // Address phase accepted
  logic         wr_go;    // Write data phase now
  logic         push;     // FIFO push
  logic         pop;      // FIFO pop
  logic [4:0]   limit;    // Current FIFO limit
  logic         full;     // FIFO at limit
  logic         empty;    // FIFO holds nothing
  logic [1:0]   ev;       // Events this cycle
  logic [1:0]   clr;      // Status read clear
  logic [31:0]  rd_val;   // Read mux
  logic         eng_busy; // Engine in flight
  logic         eng_done; // Engine finished
  logic [31:0]  eng_crc;  // Engine remainder

  // --------------------------------------------------------------
  // Configuration and FIFO flags
  // --------------------------------------------------------------
  assign cfg.data_word_width_minus_one = st.data_word_width_minus_one;
  assign cfg.poly_length_minus_one     = st.poly_length_minus_one;
  assign cfg.poly = {st.poly_hi, st.poly_lo, 1'b1};
  assign cfg.lsb_first_select          = st.lsb_first_select;

  // Limit shrinks for long polynomials
  assign limit = (st.poly_length_minus_one >= LEN_SPLIT) ? DEPTH_LONG
               : DEPTH_SHRT;
  assign full  = (st.valid_word_count >= limit);
  assign empty = (st.valid_word_count == 5'h00);

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  assign take  = hsel && htrans[1] && hready;
  assign wr_go = st.wr_pend;
  assign push  = wr_go && (st.addr == OFS_DATA) && !full;
  // Feed engine while started and idle
  assign pop   = st.shifter_go && !empty && !eng_busy;

  // Event choice: drained early or result ready
  always_comb begin
    ev         = 2'b00;
    ev[EV_OVF] = wr_go && (st.addr == OFS_DATA) && full;
    if (st.irq_event_select) begin
      ev[EV_CRC] = pop && (st.valid_word_count == 5'h01);
    end else begin
      ev[EV_CRC] = eng_done && empty;
    end
  end

  // Read mux, unmapped reads give zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (st.addr)
      OFS_CTRL: begin
        rd_val[VWC_LSB+:5] = st.valid_word_count;
        rd_val[FULL_BIT]   = full;
        rd_val[EMPTY_BIT]  = empty;
        rd_val[ISEL_BIT]   = st.irq_event_select;
        rd_val[GO_BIT]     = st.shifter_go;
        rd_val[LSBF_BIT]   = st.lsb_first_select;
      end
      OFS_CFG: begin
        // Unused bits stay zero
        rd_val[WIDTH_LSB+:5] = st.data_word_width_minus_one;
        rd_val[LEN_LSB+:5]   = st.poly_length_minus_one;
      end
      OFS_POLY_L: rd_val[15:0] = {st.poly_lo, 1'b0};
      OFS_POLY_H: rd_val[15:0] = st.poly_hi;
      OFS_RESULT: rd_val       = eng_crc;
      OFS_STAT:   rd_val[1:0]  = st.status;
      OFS_MASK:   rd_val[1:0]  = st.mask;
      default:    rd_val       = 32'h0000_0000;
    endcase
  end

  // Status cleared by its read in the wait cycle
  assign clr = (st.rd_wait && st.addr == OFS_STAT) ? 2'b11 : 2'b00;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.wr_pend = 1'b0;
    next_st.rd_wait = 1'b0;
    // Address phase
    if (take) begin
      next_st.addr    = haddr[7:0];
      next_st.wr_pend = hwrite;
      next_st.rd_wait = !hwrite;
    end
    // Read answer one wait state later
    if (st.rd_wait) begin
      next_st.hrdata = rd_val;
    end
    // Set wins over read clear
    next_st.status = (st.status & ~clr) | ev;
    // Hardware stops shifter once all work done
    if (st.shifter_go && empty && !eng_busy && !eng_done) begin
      next_st.shifter_go = 1'b0;
    end
    // Register writes
    if (wr_go) begin
      unique case (st.addr)
        OFS_CTRL: begin
          next_st.irq_event_select = hwdata[ISEL_BIT];
          next_st.shifter_go       = hwdata[GO_BIT];
          next_st.lsb_first_select = hwdata[LSBF_BIT];
        end
        OFS_CFG: begin
          next_st.data_word_width_minus_one = hwdata[WIDTH_LSB+:5];
          next_st.poly_length_minus_one     = hwdata[LEN_LSB+:5];
        end
        OFS_POLY_L: next_st.poly_lo = hwdata[15:1];
        OFS_POLY_H: next_st.poly_hi = hwdata[15:0];
        OFS_MASK:   next_st.mask    = hwdata[1:0];
        default:    next_st.mask    = st.mask;
      endcase
    end
    // FIFO storage and occupancy
    if (push) begin
      next_st.fifo[st.wr_ptr] = hwdata;
      next_st.wr_ptr          = 4'(st.wr_ptr + 4'h1);
    end
    if (pop) begin
      next_st.rd_ptr = 4'(st.rd_ptr + 4'h1);
    end
    next_st.valid_word_count = 5'(st.valid_word_count
                             + {4'h0, push} - {4'h0, pop});
  end

  // State register, all zero at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------
  // Shift engine
  // --------------------------------------------------------------
  crcw_shift_engine crcw_shift_engine_i (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .cfg        (cfg),
    .word_valid (pop),
    .word       (st.fifo[st.rd_ptr]),
    .seed_load  (wr_go && st.addr == OFS_RESULT),
    .seed       (hwdata),
    .busy       (eng_busy),
    .done       (eng_done),
    .crc        (eng_crc)
  );

  // Outputs
  assign hreadyout = !st.rd_wait;
  assign hresp     = 1'b0;
  assign hrdata    = st.hrdata;
  assign irq       = |(st.status & st.mask);

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  property p_width_wr;
    @(posedge hclk) disable iff (!hresetn)
    (wr_go && st.addr == OFS_CFG) |=>
      (cfg.data_word_width_minus_one == $past(hwdata[12:8]));
  endproperty
  a_width_wr: assert property (p_width_wr)
    else $error("width field not written");

  property p_len_mask;
    @(posedge hclk) disable iff (!hresetn)
    (eng_busy && st.poly_length_minus_one < 5'h1f) |=>
      ((eng_crc >> ($past(st.poly_length_minus_one) + 1)) == 32'h0);
  endproperty
  a_len_mask: assert property (p_len_mask)
    else $error("remainder above length");

  property p_polyl_rd;
    @(posedge hclk) disable iff (!hresetn)
    (st.rd_wait && st.addr == OFS_POLY_L) |=>
      (hrdata[0] == 1'b0 && hrdata[15:1] == st.poly_lo);
  endproperty
  a_polyl_rd: assert property (p_polyl_rd)
    else $error("low terms readback wrong");

  property p_polyh_wr;
    @(posedge hclk) disable iff (!hresetn)
    (wr_go && st.addr == OFS_POLY_H) |=>
      (cfg.poly[31:16] == $past(hwdata[15:0]));
  endproperty
  a_polyh_wr: assert property (p_polyh_wr)
    else $error("high terms not written");

  property p_cfg_rsv;
    @(posedge hclk) disable iff (!hresetn)
    (st.rd_wait && st.addr == OFS_CFG) |=>
      (hrdata[15:13] == 3'h0 && hrdata[7:5] == 3'h0);
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv)
    else $error("unused config bits set");

  property p_go_clr;
    @(posedge hclk) disable iff (!hresetn)
    (st.shifter_go && empty && !eng_busy && !eng_done && !wr_go)
      |=> !st.shifter_go;
  endproperty
  a_go_clr: assert property (p_go_clr)
    else $error("go not cleared when idle");

  property p_irq_lvl;
    @(posedge hclk) disable iff (!hresetn)
    $rose(st.status[EV_CRC]) && st.mask[EV_CRC] |-> irq;
  endproperty
  a_irq_lvl: assert property (p_irq_lvl)
    else $error("unmasked event without irq");

  property p_limit;
    @(posedge hclk) disable iff (!hresetn)
    push |=> (st.valid_word_count <= limit);
  endproperty
  a_limit: assert property (p_limit)
    else $error("word count over limit");

endmodule

// [tb_top.sv]
/*
  Self-checking bench of the programmable CRC block over AHB-Lite.
  Assumes crcw_pkg and crcw_top compiled first; hready tied to hreadyout.
*/
module tb_top
  import crcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %h got %h", nm, e, a); end end
  typedef struct {
    string       nm; // What is read
    logic [31:0] e;  // Expected value
    logic [31:0] m;  // Bits compared
  } crcw_note_type;
  logic        hclk;      // Clock
  logic        hresetn;   // Reset, low
  logic        hsel;      // Select
  logic [31:0] haddr;     // Address
  logic [1:0]  htrans;    // Transfer type
  logic        hwrite;    // Write
  logic [2:0]  hsize;     // Size
  logic [31:0] hwdata;    // Write data
  logic        hreadyout; // Slave ready
  logic        hresp;     // Response
  logic [31:0] hrdata;    // Read data
  logic        irq;       // Interrupt
  logic        rd_dp;     // Read data phase open
  crcw_note_type notes[$]; // Pending expectations
  crcw_note_type cur;      // Note being compared
  int          error_cnt; // Mismatches
  int          tests_run; // Comparisons
  logic [15:0] seed;      // Random state
  logic [31:0] r;         // Scratch read data

  crcw_top crcw_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq));

  // Clock at 40 MHz
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next random value from the shift register
  function automatic void rnd(output logic [31:0] v);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v[15:0] = seed;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v[31:16] = seed;
  endfunction

  // One single transfer, held until hready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Note an expectation, then read
  task automatic chk(input string nm, input logic [7:0] a,
                     input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] q;
    notes.push_back('{nm, e & m, m});
    bus(1'b0, a, 32'h0, q);
  endtask

  // Bounded wait for the interrupt level
  task automatic wait_irq();
    for (int c = 0; c < 300 && irq !== 1'b1; c++) @(posedge hclk);
  endtask

  // Poll until hardware drops the go bit
  task automatic wait_idle();
    do bus(1'b0, OFS_CTRL, 32'h0, r); while (r[GO_BIT] !== 1'b0);
  endtask

  // Reference remainder, Galois form with x^0 always present
  function automatic logic [31:0] crc_m(logic [31:0] c, w, p,
                                        logic [4:0] wf, lf, logic lb);
    logic        b;
    logic [31:0] k;
    k = ((32'h1 << lf) << 1) - 32'h1;
    p = (p | 32'h1) & k;
    c = c & k;
    for (int i = 0; i <= wf; i++) begin
      b = lb ? w[i] : w[wf - i];
      c = (b ^ c[lf]) ? ((c << 1) ^ p) & k : (c << 1) & k;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Result monitor: oldest note against each completed read that has a note
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      `CHK(cur.nm, cur.e, hrdata & cur.m)
      `CHK("hresp", 1'b0, hresp)
    end
    // Only reads that a note already waits for are compared
    if (hsel && htrans[1] && hreadyout === 1'b1)
      rd_dp <= !hwrite && (notes.size() > 0);
    else if (hreadyout === 1'b1) rd_dp <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Closing and watchdog
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(25 * 60000);
    error_cnt++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v, p, w, s, e;
    logic [4:0]  wf, lf;
    logic [4:0]  wfs[4];
    logic [4:0]  lfs[3];
    logic [4:0]  lim[3];
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0;
    wfs = '{5'h07, 5'h0f, 5'h1f, 5'h03};
    lfs = '{5'h03, 5'h07, 5'h08};
    lim = '{5'h10, 5'h08, 5'h08};
    hwrite = 1'b0; hsize = 3'h2; hwdata = '0; rd_dp = 1'b0;
    error_cnt = 0; tests_run = 0; seed = 16'd21152;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, empty flag up, unmapped reads zero
    chk("ctrl", OFS_CTRL, 32'h40);
    chk("cfg", OFS_CFG, 32'h0);
    chk("polyl", OFS_POLY_L, 32'h0);
    chk("polyh", OFS_POLY_H, 32'h0);
    chk("mask", OFS_MASK, 32'h0);
    chk("unmapped", 8'h20, 32'h0);
    `CHK("irq", 1'b0, irq)
    $display("test reset done");
    // Random write and read back of the config and polynomial fields
    for (int i = 0; i < 4; i++) begin
      rnd(v); wr(OFS_CFG, v);
      chk("cfg", OFS_CFG, v & 32'h1f1f);
      rnd(v); wr(OFS_POLY_L, v | 32'h1);
      chk("polyl", OFS_POLY_L, v & 32'hfffe);
      rnd(v); wr(OFS_POLY_H, v);
      chk("polyh", OFS_POLY_H, v & 32'hffff);
    end
    $display("test fields done");
    // One word per order and event choice
    for (int k = 0; k < 4; k++) begin
      wf = wfs[k];
      rnd(v); lf = v[4:0];
      wr(OFS_CFG, {19'h0, wf, 3'h0, lf});
      rnd(p);
      wr(OFS_POLY_L, p);
      wr(OFS_POLY_H, p >> 16);
      rnd(s); rnd(w);
      s = s & (((32'h1 << lf) << 1) - 32'h1);
      wr(OFS_RESULT, s);
      e = crc_m(s, w, p, wf, lf, k[0]);
      wr(OFS_MASK, 32'h1);
      wr(OFS_DATA, w);
      wr(OFS_CTRL, {26'h0, k[1], 1'b1, k[0], 3'h0});
      wait_irq();
      `CHK("irq", 1'b1, irq)
      if (!k[1]) chk("early", OFS_RESULT, e);
      wait_idle();
      chk("go", OFS_CTRL, 32'h40, 32'h50);
      chk("result", OFS_RESULT, e);
      chk("stat", OFS_STAT, 32'h1, 32'h1);
      @(posedge hclk);
      `CHK("irq", 1'b0, irq)
      chk("stat", OFS_STAT, 32'h0);
    end
    $display("test crc done");
    // Fill past the limit, then drain
    wr(OFS_MASK, 32'h2);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CFG, {27'h0, lfs[k]});
      for (int i = 0; i <= lim[k]; i++) begin
        rnd(v); wr(OFS_DATA, v);
      end
      chk("count", OFS_CTRL, {19'h0, lim[k], 8'h80}, 32'h1fc0);
      `CHK("irq", 1'b1, irq)
      chk("ovf", OFS_STAT, 32'h2, 32'h2);
      wr(OFS_CTRL, 32'h10);
      wait_idle();
      chk("drained", OFS_CTRL, 32'h40, 32'h1fc0);
      `CHK("irq", 1'b0, irq)
    end
    $display("test fifo done");
    results();
  end
endmodule
